/* File: rtl/acmpc_cfg.svh */
`ifndef ACMPC_CFG_SVH
`define ACMPC_CFG_SVH
`define ACMPC_OFS_CSR      8'h50
`define ACMPC_OFS_CCB      8'h7b
`define ACMPC_OFS_CCA      8'h7a
`define ACMPC_OFS_CHS      8'h7c
`define ACMPC_OFS_ISTAT    8'hc0
`define ACMPC_OFS_IEN      8'hc1
`define ACMPC_OFS_ICLR     8'hc2
`define ACMPC_CSR_DIS      7
`define ACMPC_CSR_BG       6
`define ACMPC_CSR_RES      5
`define ACMPC_CSR_FLAG     4
`define ACMPC_CSR_IE       3
`define ACMPC_CSR_CAP      2
`define ACMPC_CCB_MUXEN    6
`define ACMPC_CCB_CHHI     3
`define ACMPC_CCB_WMASK    8'h4f
`define ACMPC_CCA_CONVEN   7
`define ACMPC_CSR_RST      8'h00
`define ACMPC_CCB_RST      8'h00
`define ACMPC_ZERO8        8'h00
`define ACMPC_UNMAPPED     8'h00
`define ACMPC_IRQ_BITS     3
`define ACMPC_IRQ_RISE     0
`define ACMPC_IRQ_FALL     1
`define ACMPC_IRQ_EVT      2
`endif

/* File: rtl/acmpc_pkg.sv */
package acmpc_pkg;
  typedef enum logic [1:0] {
    ACMPC_MODE_TOGGLE = 2'b00,
    ACMPC_MODE_RSVD   = 2'b01,
    ACMPC_MODE_FALL   = 2'b10,
    ACMPC_MODE_RISE   = 2'b11
  } acmpc_mode_e;
  typedef logic [7:0] acmpc_byte_t;
endpackage

/* File: rtl/acmpc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser; only stage two is visible outside
module acmpc_sync (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  // data
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_r;
  logic meta_nxt;
  logic sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_o <= sync_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/acmpc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acmpc_cfg.svh"
module acmpc_top (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // analog comparator core
  input  wire logic        comparator_raw_i,
  output logic             comparator_power_down_o,
  output logic             bandgap_select_o,
  output logic             negative_from_mux_o,
  output logic [3:0]       negative_channel_o,
  // processor interrupt side
  input  wire logic        global_irq_enable_i,
  input  wire logic        vector_taken_i,
  output logic             comparator_irq_o,
  // timer capture front end
  output logic             capture_input_o,
  // system interrupt
  output logic             irq_o
);
  logic        res_sync;
  logic        res_prev_r, res_prev_nxt;
  logic [7:0]  csr_r, csr_nxt;
  logic [7:0]  ccb_r, ccb_nxt;
  logic        conv_en_r, conv_en_nxt;
  logic [2:0]  chlo_r, chlo_nxt;
  logic [2:0]  ist_r, ist_nxt;
  logic [2:0]  ien_r, ien_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wait_r, wait_nxt;
  logic        cirq_r, cirq_nxt;
  logic        irq_r, irq_nxt;
  logic        pd_r, pd_nxt, bg_r, bg_nxt, mux_r, mux_nxt;
  logic [3:0]  ch_r, ch_nxt;
  logic        cap_r, cap_nxt;
  logic        rise, fall, evt, acc, wr, rd;
  acmpc_pkg::acmpc_mode_e mode;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs);
    sel = (a == ofs);
  endfunction

  // the core does the analog compare; a powered-down core reads as zero
  acmpc_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .async_i   (comparator_raw_i & ~pd_r),
    .sync_o    (res_sync)
  );

  // single-cycle wait: request seen with waitrequest high, then taken;
  // read data is fetched on the first edge so it stands when taken
  assign acc  = (avs_read_i | avs_write_i) & wait_r;
  assign wr   = avs_write_i & ~wait_r & avs_byteenable_i[0];
  assign rd   = avs_read_i & wait_r;
  assign mode = acmpc_pkg::acmpc_mode_e'(csr_r[1:0]);
  assign rise = res_sync & ~res_prev_r;
  assign fall = ~res_sync & res_prev_r;

  always_comb begin
    case (mode)
      acmpc_pkg::ACMPC_MODE_TOGGLE: evt = rise | fall;
      acmpc_pkg::ACMPC_MODE_FALL:   evt = fall;
      acmpc_pkg::ACMPC_MODE_RISE:   evt = rise;
      default:                      evt = 1'b0;
    endcase
  end

  always_comb begin
    res_prev_nxt = res_sync;
    csr_nxt      = csr_r;
    ccb_nxt      = ccb_r;
    conv_en_nxt  = conv_en_r;
    chlo_nxt     = chlo_r;
    ien_nxt      = ien_r;
    ist_nxt      = ist_r;
    wait_nxt     = 1'b1;
    rdata_nxt    = rdata_r;
    if (wr && sel(avs_address_i, `ACMPC_OFS_CSR)) begin
      csr_nxt = {avs_writedata_i[7:6], csr_r[`ACMPC_CSR_RES],
                 csr_r[`ACMPC_CSR_FLAG], avs_writedata_i[3:0]};
      if (avs_writedata_i[`ACMPC_CSR_FLAG])
        csr_nxt[`ACMPC_CSR_FLAG] = 1'b0;
    end
    if (wr && sel(avs_address_i, `ACMPC_OFS_CCB))
      ccb_nxt = avs_writedata_i[7:0] & `ACMPC_CCB_WMASK;
    if (wr && sel(avs_address_i, `ACMPC_OFS_CCA))
      conv_en_nxt = avs_writedata_i[`ACMPC_CCA_CONVEN];
    if (wr && sel(avs_address_i, `ACMPC_OFS_CHS))
      chlo_nxt = avs_writedata_i[2:0];
    if (wr && sel(avs_address_i, `ACMPC_OFS_IEN))
      ien_nxt = avs_writedata_i[2:0];
    if (wr && sel(avs_address_i, `ACMPC_OFS_ICLR))
      ist_nxt = ist_r & ~avs_writedata_i[2:0];
    if (vector_taken_i)
      csr_nxt[`ACMPC_CSR_FLAG] = 1'b0;
    // set wins over any clear in the same cycle
    if (evt)
      csr_nxt[`ACMPC_CSR_FLAG] = 1'b1;
    ist_nxt = ist_nxt | {evt, fall, rise};
    csr_nxt[`ACMPC_CSR_RES] = res_sync;
    if (acc)
      wait_nxt = 1'b0;
    if (rd) begin
      rdata_nxt = {24'h000000, `ACMPC_UNMAPPED};
      if (sel(avs_address_i, `ACMPC_OFS_CSR)) begin
        rdata_nxt[7:0] = csr_r;
        // live result, so the status bit lags only the synchroniser
        rdata_nxt[`ACMPC_CSR_RES] = res_sync;
      end else if (sel(avs_address_i, `ACMPC_OFS_CCB))
        rdata_nxt[7:0] = ccb_r;
      else if (sel(avs_address_i, `ACMPC_OFS_CCA))
        rdata_nxt[7:0] = {conv_en_r, 7'h00};
      else if (sel(avs_address_i, `ACMPC_OFS_CHS))
        rdata_nxt[7:0] = {5'h00, chlo_r};
      else if (sel(avs_address_i, `ACMPC_OFS_ISTAT))
        rdata_nxt[7:0] = {5'h00, ist_r};
      else if (sel(avs_address_i, `ACMPC_OFS_IEN))
        rdata_nxt[7:0] = {5'h00, ien_r};
    end
  end

  always_comb begin
    pd_nxt  = csr_nxt[`ACMPC_CSR_DIS];
    bg_nxt  = csr_nxt[`ACMPC_CSR_BG];
    mux_nxt = ccb_nxt[`ACMPC_CCB_MUXEN] & ~conv_en_nxt;
    ch_nxt  = {ccb_nxt[`ACMPC_CCB_CHHI], chlo_nxt};
    cap_nxt = csr_r[`ACMPC_CSR_CAP] & res_sync;
    cirq_nxt = csr_nxt[`ACMPC_CSR_FLAG] & csr_nxt[`ACMPC_CSR_IE]
               & global_irq_enable_i;
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      res_prev_r <= 1'b0;
      csr_r      <= `ACMPC_CSR_RST;
      ccb_r      <= `ACMPC_CCB_RST;
      conv_en_r  <= 1'b0;
      chlo_r     <= 3'h0;
      ist_r      <= 3'h0;
      ien_r      <= 3'h0;
      wait_r     <= 1'b1;
      rdata_r    <= 32'h00000000;
      cirq_r     <= 1'b0;
      irq_r      <= 1'b0;
      pd_r       <= 1'b0;
      bg_r       <= 1'b0;
      mux_r      <= 1'b0;
      ch_r       <= 4'h0;
      cap_r      <= 1'b0;
    end else begin
      res_prev_r <= res_prev_nxt;
      csr_r      <= csr_nxt;
      ccb_r      <= ccb_nxt;
      conv_en_r  <= conv_en_nxt;
      chlo_r     <= chlo_nxt;
      ist_r      <= ist_nxt;
      ien_r      <= ien_nxt;
      wait_r     <= wait_nxt;
      rdata_r    <= rdata_nxt;
      cirq_r     <= cirq_nxt;
      irq_r      <= irq_nxt;
      pd_r       <= pd_nxt;
      bg_r       <= bg_nxt;
      mux_r      <= mux_nxt;
      ch_r       <= ch_nxt;
      cap_r      <= cap_nxt;
    end
  end

  assign avs_readdata_o          = rdata_r;
  assign avs_waitrequest_o       = wait_r;
  assign comparator_power_down_o = pd_r;
  assign bandgap_select_o        = bg_r;
  assign negative_from_mux_o     = mux_r;
  assign negative_channel_o      = ch_r;
  assign comparator_irq_o        = cirq_r;
  assign capture_input_o         = cap_r;
  assign irq_o                   = irq_r;

  property p_res_follows;
    @(posedge sys_clk_i) disable iff (srst_i)
      (rd && sel(avs_address_i, `ACMPC_OFS_CSR))
      |=> (avs_readdata_o[`ACMPC_CSR_RES] == $past(res_sync));
  endproperty
  a_res_follows: assert property (p_res_follows)
    else $error("result bit lag");

  property p_mux_sel;
    @(posedge sys_clk_i) disable iff (srst_i)
      (ccb_r[`ACMPC_CCB_MUXEN] && !conv_en_r)
      |=> mux_r || $changed(ccb_r) || $changed(conv_en_r);
  endproperty
  a_mux_sel: assert property (p_mux_sel)
    else $error("mux not selected");

  property p_pin_sel;
    @(posedge sys_clk_i) disable iff (srst_i)
      $past(conv_en_nxt) |-> !mux_r;
  endproperty
  a_pin_sel: assert property (p_pin_sel)
    else $error("pin not selected");

  property p_rise_flag;
    @(posedge sys_clk_i) disable iff (srst_i)
      (mode == acmpc_pkg::ACMPC_MODE_RISE && rise)
      |=> csr_r[`ACMPC_CSR_FLAG];
  endproperty
  a_rise_flag: assert property (p_rise_flag)
    else $error("rise missed");

  property p_rsvd;
    @(posedge sys_clk_i) disable iff (srst_i)
      (mode == acmpc_pkg::ACMPC_MODE_RSVD && !csr_r[`ACMPC_CSR_FLAG]
       && !wr) |=> !csr_r[`ACMPC_CSR_FLAG];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved mode set flag");

  property p_vec_clr;
    @(posedge sys_clk_i) disable iff (srst_i)
      (vector_taken_i && !evt) |=> !csr_r[`ACMPC_CSR_FLAG];
  endproperty
  a_vec_clr: assert property (p_vec_clr)
    else $error("flag not cleared");

  property p_irq_gate;
    @(posedge sys_clk_i) disable iff (srst_i)
      comparator_irq_o |-> $past(global_irq_enable_i);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq without gie");

  property p_cap;
    @(posedge sys_clk_i) disable iff (srst_i)
      !$past(csr_r[`ACMPC_CSR_CAP]) |-> !capture_input_o;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture leaked");

  property p_pd;
    @(posedge sys_clk_i) disable iff (srst_i)
      (csr_r[`ACMPC_CSR_DIS] && !wr) |=> comparator_power_down_o;
  endproperty
  a_pd: assert property (p_pd)
    else $error("power down missing");
endmodule
`default_nettype wire

/* File: bench/acmpc_comparator_model.sv */
`timescale 1ns/1ps
`default_nettype none
// comparator core: picks both inputs from the block's select lines
module acmpc_comparator_model #(
  parameter int BANDGAP_MV = 550
) (
  // selection from the block
  input  wire logic       power_down_i,
  input  wire logic       bandgap_i,
  input  wire logic       from_mux_i,
  input  wire logic [3:0] channel_i,
  // analog levels in millivolts
  input  var  int         pos_mv_i,
  input  var  int         neg_mv_i,
  input  var  int         ch_mv_i [16],
  // raw comparator output
  output logic            raw_o
);
  int p;
  int n;
  always_comb begin
    p = bandgap_i ? BANDGAP_MV : pos_mv_i;
    // channel mux taken as powered: converter power reduction held clear
    n = from_mux_i ? ch_mv_i[channel_i] : neg_mv_i;
    // unpowered core is held low rather than left floating
    raw_o = !power_down_i && (p > n);
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int BG = 550;
  logic        sys_clk_i;
  logic        srst_i;
  logic [7:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic [31:0] q;
  logic        wait_o, raw, pd, bgs, nmux, cirq, cap, irq, gie, vt;
  logic [3:0]  nch;
  int          pos_mv, neg_mv;
  int          ch_mv [16];
  int          failures, n_compared;
  logic [7:0]  m_csr, m_ccb, m_cca, m_chs, m_ien, m_ist;
  logic        m_flag, m_res;
  logic [7:0]  al [7] = '{8'h50, 8'h7b, 8'h7a, 8'h7c, 8'hc0, 8'hc1, 8'h33};

  acmpc_top uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
    .comparator_raw_i(raw), .comparator_power_down_o(pd),
    .bandgap_select_o(bgs), .negative_from_mux_o(nmux),
    .negative_channel_o(nch), .global_irq_enable_i(gie),
    .vector_taken_i(vt), .comparator_irq_o(cirq),
    .capture_input_o(cap), .irq_o(irq));
  acmpc_comparator_model #(.BANDGAP_MV(BG)) core (.power_down_i(pd),
    .bandgap_i(bgs), .from_mux_i(nmux), .channel_i(nch),
    .pos_mv_i(pos_mv), .neg_mv_i(neg_mv), .ch_mv_i(ch_mv), .raw_o(raw));

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic ref_res();
    int p;
    int n;
    p = m_csr[6] ? BG : pos_mv;
    n = (m_ccb[6] && !m_cca[7]) ? ch_mv[{m_ccb[3], m_chs[2:0]}] : neg_mv;
    return !m_csr[7] && (p > n);
  endfunction

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    // only the watchdog ends a wait that never comes
    do begin
      @(posedge sys_clk_i);
    end while (wait_o !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // waits out sync, flag and irq stages, then steps the reference
  task automatic settle();
    logic nr;
    logic ev;
    repeat (6) @(posedge sys_clk_i);
    nr = ref_res();
    case (m_csr[1:0])
      2'b00: ev = nr ^ m_res;
      2'b10: ev = m_res & !nr;
      2'b11: ev = !m_res & nr;
      default: ev = 1'b0;
    endcase
    m_flag |= ev;
    m_ist |= {ev, m_res & !nr, !m_res & nr};
    m_res = nr;
    chk(cirq, m_flag & m_csr[3] & gie);
    chk(irq, |(m_ist & m_ien));
    chk(cap, m_csr[2] & m_res);
    chk(pd, m_csr[7]);
    chk(bgs, m_csr[6]);
    chk(nmux, m_ccb[6] & !m_cca[7]);
    if (m_ccb[6] && !m_cca[7]) chk(nch, {m_ccb[3], m_chs[2:0]});
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    if (be[0]) begin
      case (a)
        8'h50: m_csr = d & 8'hcf;
        8'h7b: m_ccb = d & 8'h4f;
        8'h7a: m_cca = d;
        8'h7c: m_chs = d;
        8'hc1: m_ien = d;
        8'hc2: m_ist &= ~d;
        default: ;
      endcase
      if (a == 8'h50 && d[4]) m_flag = 1'b0;
    end
    settle();
  endtask

  task automatic rreg(input logic [7:0] a);
    logic [7:0] e;
    case (a)
      8'h50: e = {m_csr[7:6], m_res, m_flag, m_csr[3:0]};
      8'h7b: e = m_ccb;
      8'h7a: e = m_cca;
      8'h7c: e = m_chs;
      8'hc0: e = m_ist;
      8'hc1: e = m_ien;
      default: e = 8'h00;
    endcase
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    failures++;
    summarize();
  end

  initial begin
    {srst_i, be} = 5'h1f;
    {addr, rd, wr, wdata, gie, vt} = '0;
    {m_csr, m_ccb, m_cca, m_chs, m_ien, m_ist, m_flag, m_res} = '0;
    {failures, n_compared, pos_mv, neg_mv} = '0;
    neg_mv = 200;
    void'($urandom(42964));
    foreach (ch_mv[i]) ch_mv[i] = $urandom_range(1000);
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    foreach (al[i]) rreg(al[i]);
    wreg(8'h33, 8'hff);
    be <= 4'h0;
    wreg(8'h7b, 8'h48);
    be <= 4'hf;
    rreg(8'h7b);
    for (int i = 0; i < 40; i++) begin
      pos_mv <= $urandom_range(1000);
      neg_mv <= $urandom_range(1000);
      gie <= 1'($urandom_range(1));
      settle();
      // interrupt enable kept clear while power and mode move
      case ($urandom_range(3))
        0: wreg(8'h50, 8'($urandom) & 8'hd7);
        1: wreg(8'h7b, 8'($urandom));
        2: wreg(8'h7a, 8'($urandom) & 8'h80);
        default: wreg(8'h7c, 8'($urandom_range(7)));
      endcase
      rreg(8'h50);
    end
    wreg(8'h7b, 8'h00);
    wreg(8'hc1, 8'h07);
    wreg(8'hc2, 8'h07);
    gie <= 1'b1;
    for (int md = 0; md < 4; md++) begin
      wreg(8'h50, 8'h10 | 8'(md));
      wreg(8'h50, 8'h0c | 8'(md));
      pos_mv <= 900;
      neg_mv <= 100;
      settle();
      rreg(8'hc0);
      pos_mv <= 50;
      settle();
      rreg(8'h50);
      wreg(8'h50, 8'h0c | 8'(md));
      vt <= 1'b1;
      @(posedge sys_clk_i);
      vt <= 1'b0;
      m_flag = 1'b0;
      settle();
      rreg(8'h50);
      wreg(8'hc2, 8'h07);
      rreg(8'hc0);
    end
    summarize();
  end
endmodule
`default_nettype wire
